// >>> hw/mpr_pkg.sv
package mpr_pkg;
  // Register indices on the serial host port
  localparam logic [6:0] MPR_ADDR_MOTION_CTRL = 7'h69;
  localparam logic [6:0] MPR_ADDR_USER_CTRL = 7'h6A;
  localparam logic [6:0] MPR_ADDR_PWR_PRI = 7'h6B;
  localparam logic [6:0] MPR_ADDR_PWR_SEC = 7'h6C;

  // Field positions, motion control
  localparam int MPR_MOTION_EN_BIT = 7;
  localparam int MPR_CMP_MODE_BIT = 6;
  localparam int MPR_CLAMP_OVR_BIT = 1;
  localparam int MPR_THR_AND_BIT = 0;
  // Field positions, user control
  localparam int MPR_FIFO_EN_BIT = 6;
  localparam int MPR_FIFO_RST_BIT = 2;
  localparam int MPR_PATH_RST_BIT = 0;
  // Field positions, primary power
  localparam int MPR_DEV_RST_BIT = 7;
  localparam int MPR_SLEEP_BIT = 6;
  localparam int MPR_CYCLE_BIT = 5;
  localparam int MPR_GSTBY_BIT = 4;
  localparam int MPR_TDIS_BIT = 3;
  localparam int MPR_CLK_SRC_LSB = 0;
  // Field positions, secondary power
  localparam int MPR_XA_STBY_BIT = 5;
  localparam int MPR_YA_STBY_BIT = 4;
  localparam int MPR_ZA_STBY_BIT = 3;

  // Values after reset
  localparam logic [7:0] MPR_RST_MOTION_CTRL = 8'h00;
  localparam logic [7:0] MPR_RST_USER_CTRL = 8'h00;
  localparam logic [7:0] MPR_RST_PWR_PRI = 8'h01;
  localparam logic [7:0] MPR_RST_PWR_SEC = 8'h00;
  // Stored bits; reserved and trigger bits read from elsewhere or zero
  localparam logic [7:0] MPR_MASK_MOTION_CTRL = 8'hC3;
  localparam logic [7:0] MPR_MASK_USER_CTRL = 8'h40;
  localparam logic [7:0] MPR_MASK_PWR_PRI = 8'h7F;
  localparam logic [7:0] MPR_MASK_PWR_SEC = 8'h3F;

  // Clock source codes
  localparam logic [2:0] MPR_CLK_AUTO_LO = 3'h1;
  localparam logic [2:0] MPR_CLK_AUTO_HI = 3'h5;
  localparam logic [2:0] MPR_CLK_STOP = 3'h7;

  // Timing
  localparam int MPR_CLK_HZ = 200_000_000;
  localparam int MPR_OSC_HZ = 20_000_000;
  localparam int MPR_FIFO_RST_CYCLES = (MPR_CLK_HZ + MPR_OSC_HZ - 1) / MPR_OSC_HZ;
  localparam int MPR_PATH_RST_CYCLES = MPR_FIFO_RST_CYCLES;
  localparam int MPR_DEV_RST_CYCLES = 16;
  localparam int MPR_WAKE_BASE_US = 1000;
  localparam int MPR_WAKE_BASE_CYCLES = MPR_WAKE_BASE_US * (MPR_CLK_HZ / 1_000_000);

  // Duty-cycle sequencer states
  typedef enum logic [2:0] {
    MPR_DC_OFF = 3'b001,
    MPR_DC_SLEEP = 3'b010,
    MPR_DC_SAMPLE = 3'b100
  } mpr_dc_e;

  // Host register request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } mpr_req_s;

  // Host register answer
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } mpr_rsp_s;

  // Controls toward the sensor core
  typedef struct packed {
    logic motion_detect_enable;
    logic compare_prev;
    logic clamp_override;
    logic threshold_and;
    logic wake_on_motion_irq;
    logic fifo_enable;
    logic fifo_reset;
    logic path_reset;
    logic sensor_clear;
    logic device_reset;
    logic sleep_mode;
    logic gyro_drive_en;
    logic gyro_sense_en;
    logic pll_en;
    logic temp_en;
    logic [2:0] accel_axis_en;
    logic wake;
    logic accel_sample;
    logic clk_use_pll;
    logic clk_stop;
  } mpr_ctrl_s;

  // Whole state of the register bank
  typedef struct packed {
    logic [7:0] motion;
    logic [7:0] user;
    logic [7:0] pwr1;
    logic [7:0] pwr2;
    logic [4:0] dev_cnt;
    logic [3:0] fifo_cnt;
    logic [3:0] path_cnt;
    mpr_dc_e dc;
    logic [31:0] base_cnt;
    logic [7:0] div_cnt;
    mpr_rsp_s rsp;
    mpr_ctrl_s ctrl;
  } mpr_state_s;
endpackage

// >>> hw/mpr_sync.sv
`timescale 1ns/1ps
// Three-stage pin synchroniser with agreement filter
module mpr_sync #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  import mpr_pkg::*;

  // All stages in one state word
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } mpr_sync_s;

  mpr_sync_s r;
  mpr_sync_s n;

  // First stage feeds only the second
  always_comb begin
    n = r;
    n.s1 = d;
    n.s2 = r.s1;
    n.s3 = r.s2;
    for (int i = 0; i < W; i++) begin
      // Change taken only once stages two and three agree
      if (r.s2[i] == r.s3[i]) begin
        n.q[i] = r.s3[i];
      end
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign q = r.q;
endmodule

// >>> hw/mpr_ctrl_regs.sv
`timescale 1ns/1ps
// Overview of operation
// - Motion bit seven enables wake-on-motion logic
// - Compare mode one compares against previous sample
// - Clamp override bit lifts output limit
// - Threshold combine: zero ORs, one ANDs axes
// - Buffer enable gates buffer and host access
// - Buffer reset pulses one oscillator cycle, self-clears
// - Path reset resets paths, clears sensor outputs
// - Device reset restores defaults, then self-clears
// - Sleep bit puts device to sleep
// - Duty cycle alternates sleep and single accel sample
// - No enabled axes: wake without sampling
// - Gyro standby keeps drive and PLL, drops sense
// - Thermal disable bit turns off temperature sensor
// - Clock field: oscillator, auto PLL, or stop
// - Clock field resets to one
// - Secondary power bits five to three stop axes
module mpr_ctrl_regs #(
  parameter int WAKE_BASE_CYCLES = mpr_pkg::MPR_WAKE_BASE_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire mpr_pkg::mpr_req_s host_req,
  output mpr_pkg::mpr_rsp_s host_rsp,
  input wire logic [7:0] sample_rate_divider,
  input wire logic pll_ready,
  input wire logic [2:0] axis_over_thresh,
  output mpr_pkg::mpr_ctrl_s ctrl
);
  import mpr_pkg::*;

  mpr_state_s r; // Registered state
  mpr_state_s n; // Next state
  logic [3:0] pin_q; // Synchronised pins
  logic pll_ok; // PLL ready, filtered
  logic [2:0] hit; // Per-axis threshold hits

  // Pins arrive from the analog side, so filter them
  mpr_sync #(
    .W(4)
  ) u_sync (
    .clk(clk),
    .reset(reset),
    .d({pll_ready, axis_over_thresh}),
    .q(pin_q)
  );

  assign pll_ok = pin_q[3];
  assign hit = pin_q[2:0];

  // Next-state logic
  always_comb begin
    logic dev_busy;
    logic wr_motion;
    logic wr_user;
    logic wr_pwr1;
    logic wr_pwr2;
    logic cycle_ok;
    logic [2:0] axis_en;
    logic [2:0] clk_code;
    logic thr_or;
    logic thr_and;
    logic gyro_on;
    dev_busy = 1'b0;
    wr_motion = 1'b0;
    wr_user = 1'b0;
    wr_pwr1 = 1'b0;
    wr_pwr2 = 1'b0;
    cycle_ok = 1'b0;
    axis_en = 3'h0;
    clk_code = 3'h0;
    thr_or = 1'b0;
    thr_and = 1'b0;
    gyro_on = 1'b0;
    n = r;

    // Writes are ignored while the device reset is running
    dev_busy = (r.dev_cnt != 5'h00);

    // Address decode for writes
    if (!host_req.wr || dev_busy) begin
      wr_motion = 1'b0;
    end else if (host_req.addr == MPR_ADDR_MOTION_CTRL) begin
      wr_motion = 1'b1;
    end else if (host_req.addr == MPR_ADDR_USER_CTRL) begin
      wr_user = 1'b1;
    end else if (host_req.addr == MPR_ADDR_PWR_PRI) begin
      wr_pwr1 = 1'b1;
    end else if (host_req.addr == MPR_ADDR_PWR_SEC) begin
      wr_pwr2 = 1'b1;
    end

    // Storage of the plain read/write fields
    if (wr_motion) begin
      n.motion = host_req.wdata & MPR_MASK_MOTION_CTRL;
    end
    if (wr_user) begin
      n.user = host_req.wdata & MPR_MASK_USER_CTRL;
    end
    if (wr_pwr1) begin
      n.pwr1 = host_req.wdata & MPR_MASK_PWR_PRI;
    end
    if (wr_pwr2) begin
      n.pwr2 = host_req.wdata & MPR_MASK_PWR_SEC;
    end

    // Buffer reset: a rewrite mid-pulse does not stretch it
    if (r.fifo_cnt != 4'h0) begin
      n.fifo_cnt = r.fifo_cnt - 4'h1;
    end else if (wr_user && host_req.wdata[MPR_FIFO_RST_BIT]) begin
      n.fifo_cnt = 4'(MPR_FIFO_RST_CYCLES);
    end

    // Signal path reset, same pulse width
    if (r.path_cnt != 4'h0) begin
      n.path_cnt = r.path_cnt - 4'h1;
    end else if (wr_user && host_req.wdata[MPR_PATH_RST_BIT]) begin
      n.path_cnt = 4'(MPR_PATH_RST_CYCLES);
    end

    // Device reset holds every field at default until done
    if (dev_busy) begin
      n.dev_cnt = r.dev_cnt - 5'h01;
    end else if (wr_pwr1 && host_req.wdata[MPR_DEV_RST_BIT]) begin
      n.dev_cnt = 5'(MPR_DEV_RST_CYCLES);
    end
    if (n.dev_cnt != 5'h00) begin
      n.motion = MPR_RST_MOTION_CTRL;
      n.user = MPR_RST_USER_CTRL;
      n.pwr1 = MPR_RST_PWR_PRI;
      n.pwr2 = MPR_RST_PWR_SEC;
      n.fifo_cnt = 4'h0;
      n.path_cnt = 4'h0;
    end

    // Readback; status bits show the running self-clearing pulses
    n.rsp.valid = host_req.rd;
    n.rsp.data = 8'h00;
    if (!host_req.rd) begin
      n.rsp.data = 8'h00;
    end else if (host_req.addr == MPR_ADDR_MOTION_CTRL) begin
      n.rsp.data = r.motion;
    end else if (host_req.addr == MPR_ADDR_USER_CTRL) begin
      n.rsp.data = r.user;
      n.rsp.data[MPR_FIFO_RST_BIT] = (r.fifo_cnt != 4'h0);
      n.rsp.data[MPR_PATH_RST_BIT] = (r.path_cnt != 4'h0);
    end else if (host_req.addr == MPR_ADDR_PWR_PRI) begin
      n.rsp.data = r.pwr1;
      n.rsp.data[MPR_DEV_RST_BIT] = dev_busy;
    end else if (host_req.addr == MPR_ADDR_PWR_SEC) begin
      n.rsp.data = r.pwr2;
    end

    // Axis enables from the standby bits
    axis_en[2] = !r.pwr2[MPR_XA_STBY_BIT];
    axis_en[1] = !r.pwr2[MPR_YA_STBY_BIT];
    axis_en[0] = !r.pwr2[MPR_ZA_STBY_BIT];

    // Clock source decode; codes 0 and 6 fall to the oscillator
    clk_code = r.pwr1[MPR_CLK_SRC_LSB +: 3];
    n.ctrl.clk_stop = (clk_code == MPR_CLK_STOP);
    n.ctrl.clk_use_pll = (clk_code >= MPR_CLK_AUTO_LO)
      && (clk_code <= MPR_CLK_AUTO_HI) && pll_ok;

    // Duty cycling only without sleep, standby or a stopped clock
    cycle_ok = r.pwr1[MPR_CYCLE_BIT] && !r.pwr1[MPR_SLEEP_BIT]
      && !r.pwr1[MPR_GSTBY_BIT] && !n.ctrl.clk_stop;

    // Duty-cycle sequencer
    n.ctrl.wake = 1'b0;
    n.ctrl.accel_sample = 1'b0;
    case (r.dc)
      MPR_DC_OFF: begin
        n.base_cnt = 32'h0;
        n.div_cnt = 8'h00;
        if (cycle_ok) begin
          n.dc = MPR_DC_SLEEP;
        end
      end
      MPR_DC_SLEEP: begin
        if (!cycle_ok) begin
          n.dc = MPR_DC_OFF;
        end else if (r.base_cnt != 32'(WAKE_BASE_CYCLES - 1)) begin
          n.base_cnt = r.base_cnt + 32'h1;
        end else if (r.div_cnt != sample_rate_divider) begin
          // Divider stretches the sleep by whole base periods
          n.base_cnt = 32'h0;
          n.div_cnt = r.div_cnt + 8'h01;
        end else begin
          n.base_cnt = 32'h0;
          n.div_cnt = 8'h00;
          n.dc = MPR_DC_SAMPLE;
          n.ctrl.wake = 1'b1;
          n.ctrl.accel_sample = (axis_en != 3'h0);
        end
      end
      MPR_DC_SAMPLE: begin
        // One cycle awake, then back to sleep
        n.dc = cycle_ok ? MPR_DC_SLEEP : MPR_DC_OFF;
      end
      default: begin
        n.dc = MPR_DC_OFF;
      end
    endcase

    // Wake-on-motion combine over the enabled axes
    thr_or = |(hit & axis_en);
    thr_and = (axis_en != 3'h0) && (&(hit | ~axis_en));
    n.ctrl.wake_on_motion_irq = r.motion[MPR_MOTION_EN_BIT] &&
      (r.motion[MPR_THR_AND_BIT] ? thr_and : thr_or);

    // Motion controls straight from the register
    n.ctrl.motion_detect_enable = r.motion[MPR_MOTION_EN_BIT];
    n.ctrl.compare_prev = r.motion[MPR_CMP_MODE_BIT];
    n.ctrl.clamp_override = r.motion[MPR_CLAMP_OVR_BIT];
    n.ctrl.threshold_and = r.motion[MPR_THR_AND_BIT];

    // Buffer enable follows its bit; reset strobes track their counters
    n.ctrl.fifo_enable = r.user[MPR_FIFO_EN_BIT];
    n.ctrl.fifo_reset = (n.fifo_cnt != 4'h0);
    n.ctrl.path_reset = (n.path_cnt != 4'h0);
    n.ctrl.sensor_clear = (n.path_cnt != 4'h0);
    n.ctrl.device_reset = (n.dev_cnt != 5'h00);

    // Power domains
    n.ctrl.sleep_mode = r.pwr1[MPR_SLEEP_BIT];
    gyro_on = !r.pwr1[MPR_SLEEP_BIT] && !r.pwr1[MPR_CYCLE_BIT];
    n.ctrl.gyro_drive_en = gyro_on;
    n.ctrl.pll_en = gyro_on && !n.ctrl.clk_stop;
    n.ctrl.gyro_sense_en = gyro_on && !r.pwr1[MPR_GSTBY_BIT];
    n.ctrl.temp_en = !r.pwr1[MPR_TDIS_BIT] && !r.pwr1[MPR_SLEEP_BIT];
    n.ctrl.accel_axis_en = r.pwr1[MPR_SLEEP_BIT] ? 3'h0 : axis_en;
  end

  // State register; the clock field comes up as auto select
  always_ff @(posedge clk) begin
    if (reset) begin
      r <= '0;
      r.motion <= MPR_RST_MOTION_CTRL;
      r.user <= MPR_RST_USER_CTRL;
      r.pwr1 <= MPR_RST_PWR_PRI;
      r.pwr2 <= MPR_RST_PWR_SEC;
      r.dc <= MPR_DC_OFF;
    end else begin
      r <= n;
    end
  end

  assign host_rsp = r.rsp;
  assign ctrl = r.ctrl;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // Detection output only with the enable bit set
  property p_motion_enable;
    ctrl.wake_on_motion_irq |-> $past(r.motion[MPR_MOTION_EN_BIT]);
  endproperty
  a_motion_enable: assert property (p_motion_enable)
    else $error("motion interrupt without enable");

  // OR combine fires on any one enabled axis
  property p_motion_or;
    (r.motion[MPR_MOTION_EN_BIT] && !r.motion[MPR_THR_AND_BIT]
      && ((hit & ~r.pwr2[5:3]) != 3'h0)) |=> ctrl.wake_on_motion_irq;
  endproperty
  a_motion_or: assert property (p_motion_or)
    else $error("motion interrupt missed in OR mode");

  // Buffer reset pulse lasts exactly one oscillator period
  property p_fifo_pulse;
    $rose(ctrl.fifo_reset) |-> ##9 ctrl.fifo_reset ##1 !ctrl.fifo_reset;
  endproperty
  a_fifo_pulse: assert property (p_fifo_pulse)
    else $error("buffer reset pulse width wrong");

  // Path reset also clears the sensor outputs
  property p_path_reset;
    (host_req.wr && host_req.addr == MPR_ADDR_USER_CTRL && host_req.wdata[0]
      && r.dev_cnt == 5'h00 && r.path_cnt == 4'h0)
      |=> ctrl.path_reset && ctrl.sensor_clear;
  endproperty
  a_path_reset: assert property (p_path_reset)
    else $error("path reset did not start");

  // Device reset runs its course and leaves defaults
  property p_dev_reset;
    $rose(ctrl.device_reset) |-> ##15 ctrl.device_reset
      ##1 (!ctrl.device_reset && r.pwr1 == MPR_RST_PWR_PRI);
  endproperty
  a_dev_reset: assert property (p_dev_reset)
    else $error("device reset sequence wrong");

  // Sleep drops gyro and thermal sensor
  property p_sleep;
    r.pwr1[MPR_SLEEP_BIT] |=> (!ctrl.gyro_drive_en && !ctrl.temp_en);
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep left sensors on");

  // A sample is always taken inside a wake slot
  property p_cycle_sample;
    ctrl.accel_sample |-> ctrl.wake ##1 !ctrl.wake;
  endproperty
  a_cycle_sample: assert property (p_cycle_sample)
    else $error("sample outside single wake slot");

  // Wake without any axis takes no sample
  property p_wake_no_axis;
    (ctrl.wake && $past(r.pwr2[5:3]) == 3'h7) |-> !ctrl.accel_sample;
  endproperty
  a_wake_no_axis: assert property (p_wake_no_axis)
    else $error("sample taken with all axes off");

  // Gyro standby keeps drive while sense is off
  property p_gyro_standby;
    (r.pwr1[6:4] == 3'h1) |=> (ctrl.gyro_drive_en && !ctrl.gyro_sense_en);
  endproperty
  a_gyro_standby: assert property (p_gyro_standby)
    else $error("gyro standby power state wrong");

  // Thermal disable reaches the sensor
  property p_thermal_sensor_disable;
    r.pwr1[MPR_TDIS_BIT] |=> !ctrl.temp_en;
  endproperty
  a_thermal_sensor_disable: assert property (p_thermal_sensor_disable)
    else $error("temperature sensor not disabled");

  // Stop code halts the clock and never picks the PLL
  property p_clk_stop;
    (r.pwr1[2:0] == 3'h7) |=> (ctrl.clk_stop && !ctrl.clk_use_pll);
  endproperty
  a_clk_stop: assert property (p_clk_stop)
    else $error("stop code did not stop clock");

  // Oscillator codes never choose the PLL
  property p_clk_osc;
    (r.pwr1[2:0] == 3'h0 || r.pwr1[2:0] == 3'h6) |=> !ctrl.clk_use_pll;
  endproperty
  a_clk_osc: assert property (p_clk_osc)
    else $error("oscillator code picked PLL");

  // Clock field starts at auto select
  property p_clk_default;
    $fell(reset) |-> (r.pwr1[2:0] == 3'h1);
  endproperty
  a_clk_default: assert property (p_clk_default)
    else $error("clock field default wrong");
endmodule

// >>> tb/mpr_host_model.sv
`timescale 1ns/1ps
// Host processor on the register port
module mpr_host_model (
  input wire logic clk,
  output mpr_pkg::mpr_req_s host_req,
  input wire mpr_pkg::mpr_rsp_s host_rsp
);
  import mpr_pkg::*;

  // Idle request from time zero
  initial begin
    host_req = '0;
  end

  // One write strobe, held across one sampling edge
  task automatic wr(input logic [6:0] addr, input logic [7:0] data);
    logic [7:0] d;
    d = data;
    // Compare mode zero is never programmed
    if (addr == MPR_ADDR_MOTION_CTRL) begin
      d[MPR_CMP_MODE_BIT] = 1'b1;
    end
    @(posedge clk);
    #1;
    host_req = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: d};
    @(posedge clk);
    #1;
    // Released lines show the inverse, not the stale value
    host_req = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~d};
  endtask

  // One read strobe; answer taken right after the sampling edge
  task automatic rd(input logic [6:0] addr, output logic [7:0] data, output logic valid);
    @(posedge clk);
    #1;
    host_req = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'hA5};
    @(posedge clk);
    #1;
    valid = host_rsp.valid;
    data = host_rsp.data;
    host_req = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: 8'h5A};
  endtask

  // Power-up setup: clamp override and clock code one
  task automatic init();
    wr(MPR_ADDR_MOTION_CTRL, 8'h42);
    wr(MPR_ADDR_PWR_PRI, 8'h01);
  endtask
endmodule

// >>> tb/motion_sensor_control_power_regs_tb_top.sv
`timescale 1ns/1ps
// Register bank bench: host calls with expected values
module motion_sensor_control_power_regs_tb_top;
  import mpr_pkg::*;
  localparam int BASE = 8; // Short wake base keeps the run brief
  localparam int LIMIT = 6000; // Cycle ceiling for a hung run
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] div = 8'h01;
  logic pll_ready = 1'b1;
  logic [2:0] hits = 3'h0;
  mpr_req_s host_req;
  mpr_rsp_s host_rsp;
  mpr_ctrl_s ctrl;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  int n;

  // 200 MHz clock
  always #2.5 clk = ~clk;

  mpr_ctrl_regs #(.WAKE_BASE_CYCLES(BASE)) dut_u (
    .clk(clk),
    .reset(reset),
    .host_req(host_req),
    .host_rsp(host_rsp),
    .sample_rate_divider(div),
    .pll_ready(pll_ready),
    .axis_over_thresh(hits),
    .ctrl(ctrl)
  );

  mpr_host_model host_u (
    .clk(clk),
    .host_req(host_req),
    .host_rsp(host_rsp)
  );

  // Verdict and end of run, one place only
  task automatic end_sim();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      miscompares = miscompares + 1;
      end_sim();
    end
  end

  // Compare and count
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Read a register and compare answer and data
  task automatic rd_chk(input logic [6:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    logic v;
    host_u.rd(addr, d, v);
    chk("rsp_valid", 8'h01, {7'h00, v});
    chk($sformatf("reg_%h", addr), exp, d);
  endtask

  // Let ctrl settle a given number of edges
  task automatic settle(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  // Wait for a wake slot, bounded
  task automatic next_wake(output int gap);
    gap = 0;
    do begin
      settle(1);
      gap++;
    end while (ctrl.wake !== 1'b1 && gap < 100);
  endtask

  initial begin
    repeat (12) @(posedge clk);
    #1;
    reset = 1'b0;
    settle(2);
    // Register defaults
    rd_chk(MPR_ADDR_MOTION_CTRL, 8'h00);
    rd_chk(MPR_ADDR_USER_CTRL, 8'h00);
    rd_chk(MPR_ADDR_PWR_PRI, 8'h01);
    rd_chk(MPR_ADDR_PWR_SEC, 8'h00);
    rd_chk(7'h70, 8'h00);
    host_u.init();
    settle(2);
    chk("clamp", 8'h01, {7'h00, ctrl.clamp_override});
    // Motion control bits; reserved bits read zero
    host_u.wr(MPR_ADDR_MOTION_CTRL, 8'hFF);
    rd_chk(MPR_ADDR_MOTION_CTRL, 8'hC3);
    chk("motion_bits", 8'h0F, {4'h0, ctrl.motion_detect_enable, ctrl.compare_prev,
        ctrl.clamp_override, ctrl.threshold_and});
    // AND combining: one axis is not enough, all three are
    hits = 3'b100;
    settle(7);
    chk("irq_and_one", 8'h00, {7'h00, ctrl.wake_on_motion_irq});
    hits = 3'b111;
    settle(7);
    chk("irq_and_all", 8'h01, {7'h00, ctrl.wake_on_motion_irq});
    // OR combining with one axis over
    hits = 3'b010;
    host_u.wr(MPR_ADDR_MOTION_CTRL, 8'hC0);
    settle(7);
    chk("irq_or", 8'h01, {7'h00, ctrl.wake_on_motion_irq});
    host_u.wr(MPR_ADDR_MOTION_CTRL, 8'h40);
    settle(3);
    chk("irq_off", 8'h00, {7'h00, ctrl.wake_on_motion_irq});
    hits = 3'h0;
    // Buffer reset alone: pulse is already up when the write returns
    host_u.wr(MPR_ADDR_USER_CTRL, 8'h44);
    n = 0;
    while (ctrl.fifo_reset === 1'b1 && n < 40) begin
      chk("path_quiet", 8'h00, {7'h00, ctrl.path_reset});
      n++;
      settle(1);
    end
    chk("fifo_rst_len", 8'(MPR_FIFO_RST_CYCLES), 8'(n));
    chk("fifo_en", 8'h01, {7'h00, ctrl.fifo_enable});
    // Both pulses at once, readback while running, then self-clear
    host_u.wr(MPR_ADDR_USER_CTRL, 8'h45);
    settle(1);
    chk("path_pulse", 8'h03, {6'h00, ctrl.path_reset, ctrl.sensor_clear});
    rd_chk(MPR_ADDR_USER_CTRL, 8'h45);
    settle(12);
    rd_chk(MPR_ADDR_USER_CTRL, 8'h40);
    chk("path_low", 8'h00, {6'h00, ctrl.path_reset, ctrl.sensor_clear});
    host_u.wr(MPR_ADDR_USER_CTRL, 8'h00);
    settle(2);
    chk("fifo_dis", 8'h00, {7'h00, ctrl.fifo_enable});
    // Every clock source code
    for (int c = 0; c < 8; c++) begin
      host_u.wr(MPR_ADDR_PWR_PRI, {5'h00, 3'(c)});
      settle(2);
      chk("use_pll", {7'h00, 1'(c >= 1 && c <= 5)}, {7'h00, ctrl.clk_use_pll});
      chk("stop", {7'h00, 1'(c == 7)}, {7'h00, ctrl.clk_stop});
    end
    // Auto code falls back to oscillator without a locked PLL
    pll_ready = 1'b0;
    host_u.wr(MPR_ADDR_PWR_PRI, 8'h03);
    settle(7);
    chk("pll_fallback", 8'h00, {7'h00, ctrl.clk_use_pll});
    pll_ready = 1'b1;
    host_u.wr(MPR_ADDR_PWR_PRI, 8'h09);
    settle(7);
    chk("temp_off", 8'h00, {7'h00, ctrl.temp_en});
    host_u.wr(MPR_ADDR_PWR_PRI, 8'h11);
    settle(2);
    chk("gstby", 8'h05, {5'h00, ctrl.gyro_drive_en, ctrl.gyro_sense_en, ctrl.pll_en});
    host_u.wr(MPR_ADDR_PWR_PRI, 8'h01);
    settle(2);
    chk("gyro_on", 8'h07, {5'h00, ctrl.gyro_drive_en, ctrl.gyro_sense_en, ctrl.pll_en});
    chk("temp_on", 8'h01, {7'h00, ctrl.temp_en});
    host_u.wr(MPR_ADDR_PWR_SEC, 8'h20);
    settle(2);
    chk("axes", 8'h03, {5'h00, ctrl.accel_axis_en});
    host_u.wr(MPR_ADDR_PWR_SEC, 8'h00);
    host_u.wr(MPR_ADDR_PWR_PRI, 8'h41);
    settle(2);
    chk("sleep", 8'h10, {3'h0, ctrl.sleep_mode, 1'b0, ctrl.accel_axis_en});
    // Duty cycle: gap between wake slots follows the divider
    host_u.wr(MPR_ADDR_PWR_PRI, 8'h21);
    next_wake(n);
    next_wake(n);
    // Sleep of base times (divider + 1), plus the one awake cycle
    chk("wake_gap", 8'(BASE * 2 + 1), 8'(n));
    chk("sample", 8'h01, {7'h00, ctrl.accel_sample});
    // All axes off: wake continues, no sample
    host_u.wr(MPR_ADDR_PWR_SEC, 8'h38);
    next_wake(n);
    next_wake(n);
    chk("wake_noaxis", 8'h01, {7'h00, ctrl.wake});
    chk("no_sample", 8'h00, {7'h00, ctrl.accel_sample});
    // Device reset restores defaults and self-clears
    host_u.wr(MPR_ADDR_MOTION_CTRL, 8'hC3);
    host_u.wr(MPR_ADDR_PWR_PRI, 8'h80);
    rd_chk(MPR_ADDR_PWR_PRI, 8'h81);
    chk("dev_rst_run", 8'h01, {7'h00, ctrl.device_reset});
    settle(MPR_DEV_RST_CYCLES + 2);
    rd_chk(MPR_ADDR_PWR_PRI, 8'h01);
    chk("dev_rst_done", 8'h00, {7'h00, ctrl.device_reset});
    rd_chk(MPR_ADDR_MOTION_CTRL, 8'h00);
    rd_chk(MPR_ADDR_PWR_SEC, 8'h00);
    end_sim();
  end
endmodule
